// File: rtl/e1_payload_signaling_regs.sv
`timescale 1ns/1ps
// What this block does
// - Eight link copies, same offsets, 100h pages.
// - Transmit enable bit gates transmit payload; resets clear.
// - Receive enable bit gates receive replacement; resets clear.
// - Read-only busy in bit 0 per port.
// - Host never starts access while busy.
// - Control: bit 7 read flag, bits 6..0 address.
// - Host keeps payload addresses in legal ranges.
// - Host writes data before write control.
// - Read control then device fills data register.
// - Signaling port: addresses 01-0F, 11-1F, same sequences.
// - Snapshot holds first frame signaling whole multiframe.
// - Global or per-slot signaling trunk replacement.
// - Global select zero means per-slot replacement.
// - Select one forces per-slot data trunk code.
// - Select two A-law, three mu-law milliwatt.
// - Freeze holds stored signaling values.
// - De-bounce needs two identical codewords.
// - Interrupt while any change flag and enabled.
// - Change flag sets on change, write-one clears.
module e1_payload_signaling_regs
  import e1_payload_signaling_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  srst,
  e1_regbus_if.device bus,
  input  wire logic        rxValid,
  input  wire logic [2:0]  rxLink,
  input  wire logic [4:0]  rxSlot,
  input  wire logic [7:0]  rxByte,
  input  wire logic [3:0]  rxAbcd,
  input  wire logic        rxMfSync,
  input  wire logic        rxMfStart,
  output logic             outValid,
  output logic [2:0]       outLink,
  output logic [4:0]       outSlot,
  output logic [7:0]       outByte,
  output logic [3:0]       rxSignalingOut,
  output logic [7:0]       txPayloadEnable
);
  logic        txEn      [NUM_LINKS];
  logic        rxEn      [NUM_LINKS];
  logic [7:0]  rxCfg     [NUM_LINKS];
  logic [7:0]  sigCfg    [NUM_LINKS];
  logic [7:0]  payCtrl   [NUM_LINKS];
  logic [7:0]  payData   [NUM_LINKS];
  logic [7:0]  sigCtrl   [NUM_LINKS];
  logic [7:0]  sigData   [NUM_LINKS];
  logic        payBusy   [NUM_LINKS];
  logic        sigBusy   [NUM_LINKS];
  logic [29:0] changed   [NUM_LINKS];
  logic [2:0]  mwPhase   [NUM_LINKS];
  logic [7:0]  payTable  [0:1023];
  logic [3:0]  sigTable  [0:255];
  logic [3:0]  lastAbcd  [0:255];
  logic [3:0]  snapAbcd  [0:255];
  logic        payPend;
  logic        sigPend;
  logic [2:0]  payLink;
  logic [2:0]  sigLink;
  logic [7:0]  readMux;

  logic [2:0]  link;
  logic [7:0]  off;
  logic        wr;
  logic [7:0]  wd;
  assign link = bus.busAddr[10:8];
  assign off  = bus.busAddr[7:0];
  assign wr   = bus.busWr;
  assign wd   = bus.busWdata;

  // Direct control registers, one copy per link.
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (srst)
      begin
        txEn[i]    <= 1'b0;
        rxEn[i]    <= 1'b0;
        rxCfg[i]   <= RESET_BYTE;
        sigCfg[i]  <= RESET_BYTE;
        payCtrl[i] <= RESET_BYTE;
        sigCtrl[i] <= RESET_BYTE;
      end
      else if (wr && link == 3'(i))
      begin
        if (off == OFF_TX_ENABLE)
          txEn[i] <= wd[ENABLE_BIT];
        if (off == OFF_RX_ENABLE)
          rxEn[i] <= wd[ENABLE_BIT];
        if (off == OFF_RX_CONFIG)
          rxCfg[i] <= wd & RX_CONFIG_MASK;
        if (off == OFF_SIG_CONFIG)
          sigCfg[i] <= wd & SIG_CONFIG_MASK;
        if (off == OFF_PAY_CONTROL)
          payCtrl[i] <= wd;
        if (off == OFF_SIG_CONTROL)
          sigCtrl[i] <= wd;
      end
    end
  end

  // A control write marks the port busy; the table access runs on the next edge.
  // Only one bus write arrives per cycle, so one pending slot per port suffices.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      payPend <= 1'b0;
      sigPend <= 1'b0;
      payLink <= 3'h0;
      sigLink <= 3'h0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        payBusy[i] <= 1'b0;
        sigBusy[i] <= 1'b0;
      end
    end
    else
    begin
      payPend <= wr && off == OFF_PAY_CONTROL;
      sigPend <= wr && off == OFF_SIG_CONTROL;
      if (wr && off == OFF_PAY_CONTROL)
        payLink <= link;
      if (wr && off == OFF_SIG_CONTROL)
        sigLink <= link;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        if (wr && off == OFF_PAY_CONTROL && link == 3'(i))
          payBusy[i] <= 1'b1;
        else if (payPend && payLink == 3'(i))
          payBusy[i] <= 1'b0;
        if (wr && off == OFF_SIG_CONTROL && link == 3'(i))
          sigBusy[i] <= 1'b1;
        else if (sigPend && sigLink == 3'(i))
          sigBusy[i] <= 1'b0;
      end
    end
  end

  // Data registers take host writes, or the table byte when a read completes.
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (srst)
      begin
        payData[i] <= RESET_BYTE;
        sigData[i] <= RESET_BYTE;
      end
      else
      begin
        if (payPend && payLink == 3'(i) && payCtrl[i][RNW_BIT])
          payData[i] <= payTable[{payLink, payCtrl[i][6:0]}];
        else if (wr && link == 3'(i) && off == OFF_PAY_DATA)
          payData[i] <= wd;
        if (sigPend && sigLink == 3'(i) && sigCtrl[i][RNW_BIT])
          sigData[i] <= {4'h0, sigTable[{sigLink, sigCtrl[i][4:0]}]};
        else if (wr && link == 3'(i) && off == OFF_SIG_DATA)
          sigData[i] <= wd;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (payPend && !payCtrl[payLink][RNW_BIT] && payloadAddrOk(payCtrl[payLink][6:0]))
      payTable[{payLink, payCtrl[payLink][6:0]}] <= payData[payLink];
  end

  // Receive datapath lookups.
  logic [7:0] cfg;
  logic [7:0] scfg;
  logic [2:0] mode;
  logic [7:0] sigEntry;
  logic [7:0] sIdx;
  logic       sigSlot;
  logic       accept;
  logic       update;
  logic       snapOn;
  logic [4:0] flagIdx;
  logic [3:0] sigPass;
  logic [7:0] next_byte;
  logic [3:0] next_abcd;
  assign cfg      = rxCfg[rxLink];
  assign scfg     = sigCfg[rxLink];
  assign sIdx     = {rxLink, rxSlot};
  assign sigEntry = payTable[{rxLink, BANK_SIGNAL, rxSlot}];
  assign sigSlot  = rxSlot != SLOT_FRAMING && rxSlot != SLOT_SIGNALING;
  assign accept   = !scfg[DEBOUNCE_BIT] || rxAbcd == lastAbcd[sIdx];
  assign update   = rxValid && sigSlot && !scfg[FREEZE_BIT] && accept;
  assign snapOn   = cfg[SNAP_BIT] && rxMfSync;
  assign flagIdx  = (rxSlot < SLOT_SIGNALING) ? 5'(rxSlot - 5'h1) : 5'(rxSlot - 5'h2);
  assign mode     = (cfg[2:0] == REPL_NONE) ?
                    payTable[{rxLink, BANK_SELECT, rxSlot}][7:5] : cfg[2:0];
  assign sigPass  = (snapOn && !rxMfStart) ? snapAbcd[sIdx] : rxAbcd;

  always_comb
  begin
    next_byte = rxByte;
    next_abcd = sigPass;
    if (rxEn[rxLink])
    begin
      unique case (mode)
        REPL_TRUNK: next_byte = payTable[{rxLink, BANK_TRUNK, rxSlot}];
        REPL_ALAW:  next_byte = ALAW_MW[mwPhase[rxLink]];
        REPL_MULAW: next_byte = MULAW_MW[mwPhase[rxLink]];
        default:    next_byte = rxByte;
      endcase
      if (sigSlot && (cfg[GTRUNK_BIT] || sigEntry[STRUNK_BIT]))
        next_abcd = sigEntry[3:0];
    end
  end

  // Host writes to the signaling buffer win over a same-cycle line update.
  always_ff @(posedge clock)
  begin
    if (rxValid && sigSlot)
      lastAbcd[sIdx] <= rxAbcd;
    if (rxValid && snapOn && rxMfStart)
      snapAbcd[sIdx] <= rxAbcd;
    if (update)
      sigTable[sIdx] <= rxAbcd;
    if (sigPend && !sigCtrl[sigLink][RNW_BIT] && sigAddrOk(sigCtrl[sigLink][6:0]))
      sigTable[{sigLink, sigCtrl[sigLink][4:0]}] <= sigData[sigLink][3:0];
  end

  // Change flags: a set in the clearing cycle survives.
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (srst)
      begin
        changed[i] <= 30'h0;
        mwPhase[i] <= 3'h0;
      end
      else
      begin
        logic [29:0] clr;
        logic [29:0] set;
        clr = 30'h0;
        set = 30'h0;
        if (wr && link == 3'(i) && off >= OFF_CHANGE0 && off <= OFF_CHANGE3)
          clr = 30'({24'h0, wd} << (8 * (off - OFF_CHANGE0)));
        if (update && rxLink == 3'(i) && rxAbcd != sigTable[sIdx])
          set[flagIdx] = 1'b1;
        changed[i] <= (changed[i] & ~clr) | set;
        if (rxValid && rxLink == 3'(i) && rxSlot == SLOT_FRAMING)
          mwPhase[i] <= mwPhase[i] + 3'h1;
      end
    end
  end

  always_comb
  begin
    readMux = RESET_BYTE;
    unique case (off)
      OFF_TX_ENABLE:   readMux = {7'h0, txEn[link]};
      OFF_PAY_STATUS:  readMux = {7'h0, payBusy[link]};
      OFF_PAY_CONTROL: readMux = payCtrl[link];
      OFF_PAY_DATA:    readMux = payData[link];
      OFF_RX_CONFIG:   readMux = rxCfg[link];
      OFF_RX_ENABLE:   readMux = {7'h0, rxEn[link]};
      OFF_SIG_CONFIG:  readMux = sigCfg[link];
      OFF_SIG_STATUS:  readMux = {7'h0, sigBusy[link]};
      OFF_SIG_CONTROL: readMux = sigCtrl[link];
      OFF_SIG_DATA:    readMux = sigData[link];
      8'hD6:           readMux = changed[link][7:0];
      8'hD7:           readMux = changed[link][15:8];
      8'hD8:           readMux = changed[link][23:16];
      OFF_CHANGE3:     readMux = {2'h0, changed[link][29:24]};
      default:         readMux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bus.busRdata    <= RESET_BYTE;
      bus.irq         <= 1'b0;
      txPayloadEnable <= 8'h00;
      outValid        <= 1'b0;
      outLink         <= 3'h0;
      outSlot         <= 5'h0;
      outByte         <= 8'h00;
      rxSignalingOut  <= 4'h0;
    end
    else
    begin
      logic anyIrq;
      anyIrq = 1'b0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        anyIrq = anyIrq | (sigCfg[i][IRQ_EN_BIT] && changed[i] != 30'h0);
        txPayloadEnable[i] <= txEn[i];
      end
      bus.irq        <= anyIrq;
      bus.busRdata   <= bus.busRd ? readMux : RESET_BYTE;
      outValid       <= rxValid;
      outLink        <= rxLink;
      outSlot        <= rxSlot;
      outByte        <= next_byte;
      rxSignalingOut <= next_abcd;
    end
  end
endmodule

// File: common/e1_payload_signaling_pkg.sv
package e1_payload_signaling_pkg;
  localparam int          NUM_LINKS        = 8;
  localparam int          BUS_ADDR_W       = 11;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;
  // Low offsets inside each link's page; the page number is address bits 10..8.
  localparam logic [7:0]  OFF_TX_ENABLE    = 8'hCC;
  localparam logic [7:0]  OFF_PAY_STATUS   = 8'hCD;
  localparam logic [7:0]  OFF_PAY_CONTROL  = 8'hCE;
  localparam logic [7:0]  OFF_PAY_DATA     = 8'hCF;
  localparam logic [7:0]  OFF_RX_CONFIG    = 8'hD0;
  localparam logic [7:0]  OFF_RX_ENABLE    = 8'hD1;
  localparam logic [7:0]  OFF_SIG_CONFIG   = 8'hD2;
  localparam logic [7:0]  OFF_SIG_STATUS   = 8'hD3;
  localparam logic [7:0]  OFF_SIG_CONTROL  = 8'hD4;
  localparam logic [7:0]  OFF_SIG_DATA     = 8'hD5;
  localparam logic [7:0]  OFF_CHANGE0      = 8'hD6;
  localparam logic [7:0]  OFF_CHANGE3      = 8'hD9;
  localparam int          ENABLE_BIT       = 0;
  localparam int          BUSY_BIT         = 0;
  localparam int          RNW_BIT          = 7;
  localparam int          SNAP_BIT         = 7;
  localparam int          GTRUNK_BIT       = 6;
  localparam int          FREEZE_BIT       = 3;
  localparam int          DEBOUNCE_BIT     = 2;
  localparam int          IRQ_EN_BIT       = 1;
  localparam int          STRUNK_BIT       = 4;
  localparam logic [7:0]  RX_CONFIG_MASK   = 8'hC7;
  localparam logic [7:0]  SIG_CONFIG_MASK  = 8'h0E;
  localparam logic [7:0]  CHANGE3_MASK     = 8'h3F;
  // Indirect payload table banks, selected by indirect address bits 6..5.
  localparam logic [1:0]  BANK_SELECT      = 2'h0;
  localparam logic [1:0]  BANK_TRUNK       = 2'h1;
  localparam logic [1:0]  BANK_SIGNAL      = 2'h2;
  localparam logic [2:0]  REPL_NONE        = 3'h0;
  localparam logic [2:0]  REPL_TRUNK       = 3'h1;
  localparam logic [2:0]  REPL_ALAW        = 3'h2;
  localparam logic [2:0]  REPL_MULAW       = 3'h3;
  localparam logic [4:0]  SLOT_FRAMING     = 5'h00;
  localparam logic [4:0]  SLOT_SIGNALING   = 5'h10;
  localparam logic [7:0]  ALAW_MW [0:7]    = '{8'h34, 8'h21, 8'h21, 8'h34,
                                               8'hB4, 8'hA1, 8'hA1, 8'hB4};
  localparam logic [7:0]  MULAW_MW [0:7]   = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                               8'h9E, 8'h8B, 8'h8B, 8'h9E};
  // Host controller registers on its own command port.
  localparam logic [2:0]  HOST_LINK        = 3'h0;
  localparam logic [2:0]  HOST_OFFSET      = 3'h1;
  localparam logic [2:0]  HOST_DATA        = 3'h2;
  localparam logic [2:0]  HOST_CMD         = 3'h3;
  localparam logic [2:0]  HOST_STATUS      = 3'h4;
  localparam logic [2:0]  HOST_RESULT      = 3'h5;
  localparam logic [2:0]  CMD_DIRECT_WR    = 3'h0;
  localparam logic [2:0]  CMD_DIRECT_RD    = 3'h1;
  localparam logic [2:0]  CMD_PAY_WR       = 3'h2;
  localparam logic [2:0]  CMD_PAY_RD       = 3'h3;
  localparam logic [2:0]  CMD_SIG_WR       = 3'h4;
  localparam logic [2:0]  CMD_SIG_RD       = 3'h5;

  function automatic logic payloadAddrOk(input logic [6:0] a);
    return (a <= 7'h3F) || (a >= 7'h41 && a <= 7'h4F) || (a >= 7'h51 && a <= 7'h5F);
  endfunction

  function automatic logic sigAddrOk(input logic [6:0] a);
    return (a >= 7'h01 && a <= 7'h0F) || (a >= 7'h11 && a <= 7'h1F);
  endfunction
endpackage

// File: common/e1_regbus_if.sv
`timescale 1ns/1ps
interface e1_regbus_if;
  logic [10:0] busAddr;
  logic [7:0]  busWdata;
  logic        busWr;
  logic        busRd;
  logic [7:0]  busRdata;
  logic        irq;

  modport device (input busAddr, input busWdata, input busWr, input busRd,
                  output busRdata, output irq);
  modport host   (output busAddr, output busWdata, output busWr, output busRd,
                  input busRdata, input irq);
endinterface

// File: rtl/e1_regs_host.sv
`timescale 1ns/1ps
module e1_regs_host
  import e1_payload_signaling_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  srst,
  e1_regbus_if.host  bus,
  input  wire logic [2:0] cmdAddr,
  input  wire logic [7:0] cmdWdata,
  input  wire logic       cmdWr,
  input  wire logic       cmdRd,
  output logic      [7:0] cmdRdata
);
  typedef enum {H_IDLE, H_POLL, H_POLL_WAIT, H_DATA, H_CTRL, H_FETCH, H_FETCH_WAIT}
    host_state_t;

  host_state_t state;
  logic [2:0]  linkSel;
  logic [7:0]  offset;
  logic [7:0]  wrData;
  logic [7:0]  result;
  logic [2:0]  cmd;
  logic        afterOp;
  logic        irqSeen;
  logic [7:0]  portBase;
  // Status, control and data sit at base, base+1 and base+2.
  assign portBase = (cmd == CMD_SIG_WR || cmd == CMD_SIG_RD) ? OFF_SIG_STATUS : OFF_PAY_STATUS;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      linkSel <= 3'h0;
      offset  <= 8'h00;
      wrData  <= 8'h00;
    end
    else if (cmdWr && state == H_IDLE)
    begin
      if (cmdAddr == HOST_LINK)
        linkSel <= cmdWdata[2:0];
      if (cmdAddr == HOST_OFFSET)
        offset <= cmdWdata;
      if (cmdAddr == HOST_DATA)
        wrData <= cmdWdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state        <= H_IDLE;
      cmd          <= CMD_DIRECT_WR;
      afterOp      <= 1'b0;
      result       <= 8'h00;
      irqSeen      <= 1'b0;
      bus.busAddr  <= 11'h000;
      bus.busWdata <= 8'h00;
      bus.busWr    <= 1'b0;
      bus.busRd    <= 1'b0;
    end
    else
    begin
      irqSeen   <= bus.irq;
      bus.busWr <= 1'b0;
      bus.busRd <= 1'b0;
      unique case (state)
        H_IDLE:
          if (cmdWr && cmdAddr == HOST_CMD)
          begin
            cmd     <= cmdWdata[2:0];
            afterOp <= 1'b0;
            if (cmdWdata[2:0] == CMD_DIRECT_WR)
            begin
              bus.busAddr  <= {linkSel, offset};
              bus.busWdata <= wrData;
              bus.busWr    <= 1'b1;
            end
            else if (cmdWdata[2:0] == CMD_DIRECT_RD)
              state <= H_FETCH;
            else
              state <= H_POLL;
          end
        H_POLL:
        begin
          bus.busAddr <= {linkSel, portBase};
          bus.busRd   <= 1'b1;
          state       <= H_POLL_WAIT;
        end
        // Read data stand one cycle after the strobe, so wait while it is still high.
        H_POLL_WAIT:
          if (bus.busRd)
            state <= H_POLL_WAIT;
          else if (bus.busRdata[BUSY_BIT])
            state <= H_POLL;
          else if (afterOp)
            state <= (cmd == CMD_PAY_RD || cmd == CMD_SIG_RD) ? H_FETCH : H_IDLE;
          else
            state <= (cmd == CMD_PAY_WR || cmd == CMD_SIG_WR) ? H_DATA : H_CTRL;
        H_DATA:
        begin
          bus.busAddr  <= {linkSel, 8'(portBase + 8'h2)};
          bus.busWdata <= wrData;
          bus.busWr    <= 1'b1;
          state        <= H_CTRL;
        end
        H_CTRL:
        begin
          bus.busAddr  <= {linkSel, 8'(portBase + 8'h1)};
          bus.busWdata <= {cmd == CMD_PAY_RD || cmd == CMD_SIG_RD, offset[6:0]};
          bus.busWr    <= 1'b1;
          afterOp      <= 1'b1;
          state        <= H_POLL;
        end
        H_FETCH:
        begin
          bus.busAddr <= (cmd == CMD_DIRECT_RD) ? {linkSel, offset}
                                                : {linkSel, 8'(portBase + 8'h2)};
          bus.busRd   <= 1'b1;
          state       <= H_FETCH_WAIT;
        end
        H_FETCH_WAIT:
        begin
          result <= bus.busRdata;
          state  <= bus.busRd ? H_FETCH_WAIT : H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      cmdRdata <= 8'h00;
    else if (!cmdRd)
      cmdRdata <= 8'h00;
    else
    begin
      unique case (cmdAddr)
        HOST_LINK:   cmdRdata <= {5'h0, linkSel};
        HOST_OFFSET: cmdRdata <= offset;
        HOST_DATA:   cmdRdata <= wrData;
        HOST_STATUS: cmdRdata <= {6'h0, irqSeen, state != H_IDLE};
        HOST_RESULT: cmdRdata <= result;
        default:     cmdRdata <= 8'h00;
      endcase
    end
  end
endmodule

// File: testbench/e1_payload_signaling_props.sv
`timescale 1ns/1ps
module e1_payload_signaling_props
  import e1_payload_signaling_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [10:0] busAddr,
  input  wire logic [7:0]  busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  input  wire logic [7:0]  busRdata,
  input  wire logic        irq
);
  logic       lastRd;
  logic [7:0] lastOff;
  logic [7:0] irqEn;
  wire  [7:0] off = busAddr[7:0];

  always_ff @(posedge clock)
  begin
    lastRd  <= srst ? 1'b0 : busRd;
    lastOff <= off;
  end

  // Shadow of every link's interrupt enable, rebuilt from the writes seen on the bus.
  always_ff @(posedge clock)
  begin
    if (srst)
      irqEn <= 8'h00;
    else if (busWr && off == OFF_SIG_CONFIG)
      irqEn[busAddr[10:8]] <= busWdata[IRQ_EN_BIT];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_rdata_quiet: assert property (!lastRd |-> busRdata == 8'h00)
    else $error("read data driven without a read");
  a_busy_set: assert property (busWr && off == OFF_PAY_CONTROL ##1 busRd && off == OFF_PAY_STATUS
    |=> busRdata[BUSY_BIT]) else $error("busy low right after control write");
  a_busy_clear: assert property (busWr && off == OFF_SIG_CONTROL ##4 busRd && off == OFF_SIG_STATUS
    |=> !busRdata[BUSY_BIT]) else $error("busy still high");
  a_status_rsvd: assert property (lastRd && (lastOff == OFF_PAY_STATUS || lastOff == OFF_SIG_STATUS)
    |-> busRdata[7:1] == 7'h00) else $error("status reserved bits set");
  a_enable_rsvd: assert property (lastRd && (lastOff == OFF_TX_ENABLE || lastOff == OFF_RX_ENABLE)
    |-> busRdata[7:1] == 7'h00) else $error("enable reserved bits set");
  a_rx_cfg_mask: assert property (lastRd && lastOff == OFF_RX_CONFIG
    |-> (busRdata & ~RX_CONFIG_MASK) == 8'h00) else $error("config reserved bits set");
  a_sig_cfg_mask: assert property (lastRd && lastOff == OFF_SIG_CONFIG
    |-> (busRdata & ~SIG_CONFIG_MASK) == 8'h00) else $error("sig config bits set");
  a_no_start_busy: assert property (busWr && off == OFF_PAY_CONTROL
    |=> !(busWr && (off == OFF_PAY_CONTROL || off == OFF_PAY_DATA)))
    else $error("access started while busy");
  a_irq_gated: assert property ((irqEn == 8'h00) [*2] |-> !irq)
    else $error("interrupt without enable");
  a_unmapped_zero: assert property (lastRd && (lastOff < OFF_TX_ENABLE || lastOff > OFF_CHANGE3)
    |-> busRdata == 8'h00) else $error("unmapped offset read nonzero");

  c_busy_poll: cover property (busWr && off == OFF_PAY_CONTROL ##[1:40] busRd && off == OFF_PAY_STATUS);
  c_sig_poll: cover property (busWr && off == OFF_SIG_CONTROL ##[1:40] busRd && off == OFF_SIG_STATUS);
  c_irq_seen: cover property ($rose(irq));
endmodule

// File: testbench/e1_payload_signaling_regs_tb.sv
`timescale 1ns/1ps
module e1_payload_signaling_regs_tb;
  import e1_payload_signaling_pkg::*;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] cmdAddr = 3'h0;
  logic [7:0] cmdWdata = 8'h00;
  logic       cmdWr = 1'b0;
  logic       cmdRd = 1'b0;
  logic [7:0] cmdRdata;
  logic       rxValid = 1'b0;
  logic [2:0] rxLink = 3'h0;
  logic [4:0] rxSlot = 5'h00;
  logic [7:0] rxByte = 8'h00;
  logic [3:0] rxAbcd = 4'h0;
  logic       rxMfSync = 1'b0;
  logic       rxMfStart = 1'b0;
  logic       outValid;
  logic [2:0] outLink;
  logic [4:0] outSlot;
  logic [7:0] outByte;
  logic [3:0] rxSignalingOut;
  logic [7:0] txPayloadEnable;
  logic [7:0] q;
  logic [7:0] b;
  logic [4:0] sl;
  logic [7:0] tbl [0:95];
  logic [2:0] lk;
  int         fail_count = 0;
  int         checked = 0;
  int         seed = 32'hae71;

  e1_regbus_if busLink ();
  e1_regs_host e1_regs_host_i (.clock(clock), .srst(srst), .bus(busLink.host), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata));
  e1_payload_signaling_regs e1_payload_signaling_regs_i (.clock(clock), .srst(srst),
    .bus(busLink.device), .rxValid(rxValid), .rxLink(rxLink), .rxSlot(rxSlot), .rxByte(rxByte),
    .rxAbcd(rxAbcd), .rxMfSync(rxMfSync), .rxMfStart(rxMfStart), .outValid(outValid),
    .outLink(outLink), .outSlot(outSlot), .outByte(outByte), .rxSignalingOut(rxSignalingOut),
    .txPayloadEnable(txPayloadEnable));
  e1_payload_signaling_props e1_payload_signaling_props_i (.clock(clock), .srst(srst),
    .busAddr(busLink.busAddr), .busWdata(busLink.busWdata), .busWr(busLink.busWr),
    .busRd(busLink.busRd), .busRdata(busLink.busRdata), .irq(busLink.irq));

  always #12.5 clock = ~clock;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [2:0] a, input logic [7:0] d, input logic rd, output logic [7:0] r);
    @(posedge clock);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= !rd;
    cmdRd <= rd;
    @(posedge clock);
    cmdWr <= 1'b0;
    cmdRd <= 1'b0;
    #1 r = cmdRdata;
  endtask

  // Waits for the controller to go idle, so no command is ever refused for being busy.
  task automatic op(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    int         n;
    cmd(HOST_LINK, {5'h00, lk}, 1'b0, s);
    cmd(HOST_OFFSET, a, 1'b0, s);
    cmd(HOST_DATA, d, 1'b0, s);
    cmd(HOST_CMD, {5'h00, c}, 1'b0, s);
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0 && n < 200)
    begin
      cmd(HOST_STATUS, 8'h00, 1'b1, s);
      n++;
    end
    if (n == 200)
    begin
      fail_count++;
      $display("mismatch at %0t: controller stuck busy", $time);
      summarize();
    end
    cmd(HOST_RESULT, 8'h00, 1'b1, q);
  endtask

  task automatic rc(input logic [2:0] c, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    op(c, a, 8'h00);
    check(q & m, e);
  endtask

  task automatic send(input logic [4:0] s, input logic [7:0] d, input logic [3:0] ab, input logic st);
    @(posedge clock);
    rxValid <= 1'b1;
    rxLink <= lk;
    rxSlot <= s;
    rxByte <= d;
    rxAbcd <= ab;
    rxMfStart <= st;
    @(posedge clock);
    rxValid <= 1'b0;
    rxMfStart <= 1'b0;
    #1 check({outValid, outSlot, 2'h0}, {1'b1, s, 2'h0});
  endtask

  function automatic logic mwHit(input logic [7:0] v, input logic alaw);
    mwHit = 1'b0;
    for (int i = 0; i < 8; i++)
      mwHit |= (v == (alaw ? ALAW_MW[i] : MULAW_MW[i]));
  endfunction

  initial
  begin
    lk = 3'($random(seed));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 14; i++)
      rc(CMD_DIRECT_RD, OFF_TX_ENABLE + 8'(i), 8'hFF, RESET_BYTE);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      lk = 3'(i);
      op(CMD_DIRECT_WR, OFF_TX_ENABLE, 8'hFF);
      check(txPayloadEnable, 8'((2 << i) - 1));
      rc(CMD_DIRECT_RD, OFF_TX_ENABLE, 8'hFF, 8'h01);
    end
    lk = 3'($random(seed));
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'hFF);
    rc(CMD_DIRECT_RD, OFF_SIG_CONFIG, 8'hFF, 8'h0E);
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h00);
    op(CMD_DIRECT_WR, OFF_PAY_STATUS, 8'hFF);
    rc(CMD_DIRECT_RD, OFF_PAY_STATUS, 8'hFF, 8'h00);
    op(CMD_DIRECT_WR, 8'h40, 8'hFF);
    rc(CMD_DIRECT_RD, 8'h40, 8'hFF, 8'h00);
    op(CMD_DIRECT_WR, OFF_PAY_CONTROL, 8'h85);
    rc(CMD_DIRECT_RD, OFF_PAY_CONTROL, 8'hFF, 8'h85);
    op(CMD_DIRECT_WR, OFF_SIG_CONTROL, 8'h93);
    rc(CMD_DIRECT_RD, OFF_SIG_CONTROL, 8'hFF, 8'h93);
    $display("test registers done");
    for (int a = 0; a < 96; a++)
    begin
      tbl[a] = (a >= 32 && a < 64) ? 8'($random(seed)) : 8'h00;
      if (a != 64 && a != 80)
        op(CMD_PAY_WR, 8'(a), tbl[a]);
    end
    for (int a = 0; a < 96; a++)
      if (a != 64 && a != 80)
        rc(CMD_PAY_RD, 8'(a), 8'hFF, tbl[a]);
    op(CMD_SIG_WR, 8'h12, 8'h0C);
    rc(CMD_SIG_RD, 8'h12, 8'h0F, 8'h0C);
    $display("test indirect done");
    op(CMD_DIRECT_WR, OFF_RX_ENABLE, 8'h01);
    rc(CMD_DIRECT_RD, OFF_RX_ENABLE, 8'hFF, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      op(CMD_DIRECT_WR, OFF_RX_CONFIG, 8'(m));
      for (int k = 0; k < 6; k++)
      begin
        sl = 5'($random(seed));
        b = 8'($random(seed));
        send(sl, b, 4'h0, 1'b0);
        if (m < 2)
          check(outByte, m == 0 ? b : tbl[32 + sl]);
        else
          check(8'(mwHit(outByte, m == 2)), 8'h01);
      end
    end
    op(CMD_DIRECT_WR, OFF_RX_CONFIG, 8'h00);
    op(CMD_PAY_WR, 8'h07, 8'h20);
    send(5'h07, 8'h5A, 4'h0, 1'b0);
    check(outByte, tbl[39]);
    op(CMD_PAY_WR, 8'h45, 8'h1A);
    send(5'h05, 8'h00, 4'h3, 1'b0);
    check(8'(rxSignalingOut), 8'h0A);
    op(CMD_PAY_WR, 8'h49, 8'h06);
    op(CMD_DIRECT_WR, OFF_RX_CONFIG, 8'h40);
    send(5'h09, 8'h00, 4'h3, 1'b0);
    check(8'(rxSignalingOut), 8'h06);
    op(CMD_DIRECT_WR, OFF_RX_CONFIG, 8'h00);
    op(CMD_PAY_WR, 8'h45, 8'h00);
    op(CMD_DIRECT_WR, OFF_RX_ENABLE, 8'h00);
    send(5'h07, 8'h5A, 4'h0, 1'b0);
    check(outByte, 8'h5A);
    $display("test replacement done");
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h02);
    send(5'h03, 8'h00, 4'h5, 1'b0);
    send(5'h03, 8'h00, 4'h5, 1'b0);
    for (int i = 0; i < 4; i++)
      op(CMD_DIRECT_WR, OFF_CHANGE0 + 8'(i), 8'hFF);
    rc(CMD_DIRECT_RD, OFF_CHANGE0, 8'hFF, 8'h00);
    send(5'h03, 8'h00, 4'hA, 1'b0);
    rc(CMD_DIRECT_RD, OFF_CHANGE0, 8'hFF, 8'h04);
    rc(CMD_DIRECT_RD, OFF_CHANGE3, 8'hFF, 8'h00);
    cmd(HOST_STATUS, 8'h00, 1'b1, q);
    check(q & 8'h02, 8'h02);
    op(CMD_DIRECT_WR, OFF_CHANGE0, 8'h04);
    rc(CMD_DIRECT_RD, OFF_CHANGE0, 8'hFF, 8'h00);
    cmd(HOST_STATUS, 8'h00, 1'b1, q);
    check(q & 8'h02, 8'h00);
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h00);
    send(5'h03, 8'h00, 4'h5, 1'b0);
    cmd(HOST_STATUS, 8'h00, 1'b1, q);
    check(q & 8'h02, 8'h00);
    $display("test change flags done");
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h04);
    send(5'h03, 8'h00, 4'h6, 1'b0);
    rc(CMD_SIG_RD, 8'h03, 8'h0F, 8'h05);
    send(5'h03, 8'h00, 4'h6, 1'b0);
    rc(CMD_SIG_RD, 8'h03, 8'h0F, 8'h06);
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h08);
    send(5'h03, 8'h00, 4'h9, 1'b0);
    send(5'h03, 8'h00, 4'h9, 1'b0);
    rc(CMD_SIG_RD, 8'h03, 8'h0F, 8'h06);
    op(CMD_DIRECT_WR, OFF_SIG_CONFIG, 8'h00);
    $display("test debounce freeze done");
    op(CMD_DIRECT_WR, OFF_RX_ENABLE, 8'h01);
    op(CMD_DIRECT_WR, OFF_RX_CONFIG, 8'h80);
    rxMfSync <= 1'b1;
    send(5'h05, 8'h00, 4'h3, 1'b1);
    check(8'(rxSignalingOut), 8'h03);
    send(5'h05, 8'h00, 4'hC, 1'b0);
    check(8'(rxSignalingOut), 8'h03);
    $display("test snapshot done");
    summarize();
  end
endmodule
